//--- hw/csr_top.sv
// core special registers: pointers, accumulator, pc low byte, data memory routing
`timescale 1ns/10ps
module csr_top import csr_pkg::*; #(
	parameter int ADDR_W = CSR_ADDR_W,
	parameter int SECTOR_W = CSR_SECTOR_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic [7:0] cpu_wdata,
	input wire logic alu_we,
	input wire logic [7:0] alu_result,
	input wire logic [7:0] pc_low_cur,
	input wire logic [7:0] mem_rdata,
	output logic [7:0] cpu_rdata,
	output logic cpu_rvalid,
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_sfr,
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	output logic [7:0] acc,
	output logic pc_jump,
	output logic [7:0] pc_target,
	output logic pc_stall
);
	logic [7:0] ptr0_q, ptr0_d;
	logic [7:0] ptra_lo_q, ptra_lo_d;
	logic [7:0] ptra_sec_q, ptra_sec_d;
	logic [7:0] ptrb_lo_q, ptrb_lo_d;
	logic [7:0] ptrb_sec_q, ptrb_sec_d;
	logic [7:0] acc_q, acc_d;
	logic [ADDR_W-1:0] eff_addr;
	logic redirected;
	logic core_hit;
	logic [7:0] eff_lo;
	logic [7:0] sfr_val;
	logic pcl_wr;
	logic [ADDR_W-1:0] mem_addr_q, mem_addr_d;
	logic mem_sfr_q, mem_sfr_d;
	logic mem_rd_q, mem_rd_d;
	logic mem_wr_q, mem_wr_d;
	logic [7:0] mem_wdata_q, mem_wdata_d;
	logic rd_p_q, rd_p_d;
	logic sel_mem_q, sel_mem_d;
	logic [7:0] sfr_p_q, sfr_p_d;
	logic [7:0] rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;

	csr_addr_resolve #(
		.ADDR_W(ADDR_W),
		.SECTOR_W(SECTOR_W)
	) u_resolve (
		.req_addr(cpu_addr),
		.ptr0(ptr0_q),
		.ptra_lo(ptra_lo_q),
		.ptra_sec(ptra_sec_q),
		.ptrb_lo(ptrb_lo_q),
		.ptrb_sec(ptrb_sec_q),
		.eff_addr(eff_addr),
		.redirected(redirected)
	);

	// decode of the resolved address; a port reached through a pointer is still a port
	always_comb begin
		eff_lo = eff_addr[7:0];
		core_hit = (eff_addr[ADDR_W-1:8] == {SECTOR_W{1'b0}}) && (eff_lo < CSR_GP_BASE)
			&& (eff_lo[7:4] == CSR_WIN_HI) && !CSR_FWD_MASK[eff_lo[3:0]];
		sfr_val = CSR_ZERO;
		if (core_hit) begin
			unique case (eff_lo)
				CSR_OFF_PTR0: sfr_val = ptr0_q;
				CSR_OFF_PTRA_LO: sfr_val = ptra_lo_q;
				CSR_OFF_PTRA_SEC: sfr_val = ptra_sec_q;
				CSR_OFF_PTRB_LO: sfr_val = ptrb_lo_q;
				CSR_OFF_PTRB_SEC: sfr_val = ptrb_sec_q;
				CSR_OFF_ACC: sfr_val = acc_q;
				CSR_OFF_PCL: sfr_val = pc_low_cur;
				default: sfr_val = CSR_ZERO;
			endcase
		end
	end

	// pointer storage
	always_comb begin
		ptr0_d = ptr0_q;
		ptra_lo_d = ptra_lo_q;
		ptra_sec_d = ptra_sec_q;
		ptrb_lo_d = ptrb_lo_q;
		ptrb_sec_d = ptrb_sec_q;
		if (cpu_wr && core_hit) begin
			unique case (eff_lo)
				CSR_OFF_PTR0: ptr0_d = cpu_wdata;
				CSR_OFF_PTRA_LO: ptra_lo_d = cpu_wdata;
				CSR_OFF_PTRA_SEC: ptra_sec_d = cpu_wdata;
				CSR_OFF_PTRB_LO: ptrb_lo_d = cpu_wdata;
				CSR_OFF_PTRB_SEC: ptrb_sec_d = cpu_wdata;
				default: ptr0_d = ptr0_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ptr0_q <= CSR_RST_PTR;
			ptra_lo_q <= CSR_RST_PTR;
			ptra_sec_q <= CSR_RST_PTR;
			ptrb_lo_q <= CSR_RST_PTR;
			ptrb_sec_q <= CSR_RST_PTR;
		end else begin
			ptr0_q <= ptr0_d;
			ptra_lo_q <= ptra_lo_d;
			ptra_sec_q <= ptra_sec_d;
			ptrb_lo_q <= ptrb_lo_d;
			ptrb_sec_q <= ptrb_sec_d;
		end
	end

	// accumulator; the alu wins over a same-cycle register write
	always_comb begin
		acc_d = acc_q;
		if (alu_we) begin
			acc_d = alu_result;
		end else if (cpu_wr && core_hit && eff_lo == CSR_OFF_ACC) begin
			acc_d = cpu_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			acc_q <= CSR_RST_ACC;
		end else begin
			acc_q <= acc_d;
		end
	end

	assign acc = acc_q;

	assign pcl_wr = cpu_wr && core_hit && (eff_lo == CSR_OFF_PCL);

	csr_pc_jump #(
		.DUMMY(CSR_DUMMY_CYCLES)
	) u_jump (
		.ref_clk(ref_clk),
		.rst(rst),
		.pcl_wr(pcl_wr),
		.pcl_data(cpu_wdata),
		.jump_q(pc_jump),
		.target_q(pc_target),
		.stall_q(pc_stall)
	);

	// memory side request, one cycle after the cpu request
	always_comb begin
		mem_addr_d = mem_addr_q;
		mem_sfr_d = mem_sfr_q;
		mem_rd_d = 1'b0;
		mem_wr_d = 1'b0;
		mem_wdata_d = mem_wdata_q;
		if ((cpu_rd || cpu_wr) && !core_hit) begin
			mem_addr_d = eff_addr;
			mem_sfr_d = (eff_lo < CSR_GP_BASE);
			mem_rd_d = cpu_rd;
			mem_wr_d = cpu_wr;
			mem_wdata_d = cpu_wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mem_addr_q <= '0;
			mem_sfr_q <= 1'b0;
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			mem_wdata_q <= 8'h00;
		end else begin
			mem_addr_q <= mem_addr_d;
			mem_sfr_q <= mem_sfr_d;
			mem_rd_q <= mem_rd_d;
			mem_wr_q <= mem_wr_d;
			mem_wdata_q <= mem_wdata_d;
		end
	end

	assign mem_addr = mem_addr_q;
	assign mem_sfr = mem_sfr_q;
	assign mem_rd = mem_rd_q;
	assign mem_wr = mem_wr_q;
	assign mem_wdata = mem_wdata_q;

	// read return: core values are captured early so a pointer change cannot skew them
	always_comb begin
		rd_p_d = cpu_rd;
		sel_mem_d = !core_hit;
		sfr_p_d = sfr_val;
		rvalid_d = rd_p_q;
		rdata_d = rdata_q;
		if (rd_p_q) begin
			rdata_d = sel_mem_q ? mem_rdata : sfr_p_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_p_q <= 1'b0;
			sel_mem_q <= 1'b0;
			sfr_p_q <= 8'h00;
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rd_p_q <= rd_p_d;
			sel_mem_q <= sel_mem_d;
			sfr_p_q <= sfr_p_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign cpu_rdata = rdata_q;
	assign cpu_rvalid = rvalid_q;

	// checks on the routing and storage
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_ind0_redirect: assert property (
		(cpu_wr && cpu_addr == {{SECTOR_W{1'b0}}, CSR_OFF_IND0} && ptr0_q >= CSR_GP_BASE)
		|=> (mem_wr && mem_addr == {{SECTOR_W{1'b0}}, $past(ptr0_q)} && mem_wdata == $past(cpu_wdata)))
		else $error("indirect write not sent to pointer location");
	a_ind0_sector_zero: assert property (
		(cpu_rd && cpu_addr == {{SECTOR_W{1'b0}}, CSR_OFF_IND0} && ptr0_q >= CSR_GP_BASE)
		|=> (mem_rd && mem_addr[ADDR_W-1:8] == {SECTOR_W{1'b0}}))
		else $error("first port left sector zero");
	a_inda_sector_select: assert property (
		(cpu_rd && cpu_addr == {{SECTOR_W{1'b0}}, CSR_OFF_INDA} && ptra_lo_q >= CSR_GP_BASE)
		|=> (mem_rd && mem_addr == {$past(ptra_sec_q[SECTOR_W-1:0]), $past(ptra_lo_q)}))
		else $error("wide pointer address wrong");
	a_port_reads_zero: assert property (
		(cpu_rd && core_hit && (eff_lo == CSR_OFF_IND0 || eff_lo == CSR_OFF_INDA || eff_lo == CSR_OFF_INDB))
		|-> ##2 (cpu_rvalid && cpu_rdata == CSR_ZERO))
		else $error("indirect port read not zero");
	a_ptr_storage: assert property (
		(cpu_wr && core_hit && eff_lo == CSR_OFF_PTRB_SEC && !cpu_rd) ##1 (cpu_rd && cpu_addr ==
		{{SECTOR_W{1'b0}}, CSR_OFF_PTRB_SEC}) |-> ##2 (cpu_rvalid && cpu_rdata == $past(cpu_wdata, 3)))
		else $error("pointer byte did not store");
	a_unused_zero: assert property (
		(cpu_rd && cpu_addr == {{SECTOR_W{1'b0}}, 8'h0B}) |-> ##2 (cpu_rvalid && cpu_rdata == CSR_ZERO))
		else $error("unused location not zero");
	a_ext_direct: assert property (
		(cpu_rd && cpu_addr[7:0] >= CSR_GP_BASE) |=> (mem_rd && mem_addr == $past(cpu_addr) && !mem_sfr))
		else $error("extended access not direct");
	a_gp_return: assert property (
		(cpu_rd && cpu_addr[7:0] >= CSR_GP_BASE) |-> ##1 mem_rd ##1
		(cpu_rvalid && cpu_rdata == $past(mem_rdata)))
		else $error("general memory data not returned");
	a_acc_alu: assert property (
		alu_we |=> (acc == $past(alu_result)))
		else $error("alu result lost");
	a_pcl_jump: assert property (
		(pcl_wr && !pc_stall) |=> (pc_jump && pc_target == $past(cpu_wdata)))
		else $error("pcl write did not jump");
	a_dummy_cycle: assert property (
		pc_jump |-> (pc_stall ##1 !pc_stall))
		else $error("dummy cycle length wrong");
	a_ext_write: assert property (
		(cpu_wr && cpu_addr[7:0] >= CSR_GP_BASE) |=> (mem_wr && mem_addr == $past(cpu_addr) && mem_wdata == $past(cpu_wdata)))
		else $error("extended write not forwarded whole");
	a_indb_sector_select: assert property (
		(cpu_rd && cpu_addr == {{SECTOR_W{1'b0}}, CSR_OFF_INDB} && ptrb_sec_q[SECTOR_W-1:0] != {SECTOR_W{1'b0}})
		|=> (mem_rd && mem_addr == {$past(ptrb_sec_q[SECTOR_W-1:0]), $past(ptrb_lo_q)}))
		else $error("second wide pointer address wrong");
	a_port_write_nop: assert property (
		(cpu_wr && core_hit && (eff_lo == CSR_OFF_IND0 || eff_lo == CSR_OFF_INDA || eff_lo == CSR_OFF_INDB))
		|=> ($stable(ptr0_q) && $stable(ptra_lo_q) && $stable(ptra_sec_q) && $stable(ptrb_lo_q)
		&& $stable(ptrb_sec_q) && !mem_wr))
		else $error("indirect port write stored data");
	a_acc_reg_write: assert property (
		(cpu_wr && core_hit && eff_lo == CSR_OFF_ACC && !alu_we) |=> (acc == $past(cpu_wdata)))
		else $error("accumulator write lost");
	a_sfr_flag: assert property (
		((cpu_rd || cpu_wr) && !core_hit) |=> (mem_sfr == !$past(eff_addr[7])))
		else $error("special area flag wrong");
	a_pcl_no_forward: assert property (
		pcl_wr |=> (!mem_wr && !mem_rd))
		else $error("pcl write leaked to memory port");

	c_ind_a_read: cover property (cpu_rd && cpu_addr == {{SECTOR_W{1'b0}}, CSR_OFF_INDA} ##2 cpu_rvalid);
	c_ext_write: cover property (cpu_wr && cpu_addr[ADDR_W-1:8] != {SECTOR_W{1'b0}} ##1 mem_wr);
	c_pcl_jump: cover property (pc_jump ##1 !pc_stall);
	// a pointer reload read back at once, and a write through the first port
	c_ind0_write: cover property (cpu_wr && cpu_addr == {{SECTOR_W{1'b0}}, CSR_OFF_IND0} ##1 mem_wr);
	c_ptr_readback: cover property (cpu_wr && core_hit && eff_lo == CSR_OFF_PTRB_SEC ##1 cpu_rd ##2 cpu_rvalid);
endmodule

//--- hw/csr_pkg.sv
// constants and types shared by the core special register block
package csr_pkg;
	localparam int CSR_SECTOR_W = 3;
	localparam int CSR_ADDR_W = 11;
	localparam int CSR_DATA_W = 8;
	// register offsets inside sector 0
	localparam logic [7:0] CSR_OFF_IND0 = 8'h00;
	localparam logic [7:0] CSR_OFF_PTR0 = 8'h01;
	localparam logic [7:0] CSR_OFF_INDA = 8'h02;
	localparam logic [7:0] CSR_OFF_PTRA_LO = 8'h03;
	localparam logic [7:0] CSR_OFF_PTRA_SEC = 8'h04;
	localparam logic [7:0] CSR_OFF_ACC = 8'h05;
	localparam logic [7:0] CSR_OFF_PCL = 8'h06;
	localparam logic [7:0] CSR_OFF_INDB = 8'h0C;
	localparam logic [7:0] CSR_OFF_PTRB_LO = 8'h0D;
	localparam logic [7:0] CSR_OFF_PTRB_SEC = 8'h0E;
	// first location of general purpose memory in a sector
	localparam logic [7:0] CSR_GP_BASE = 8'h80;
	// the core owns locations 00H-0FH of sector 0; set bits are forwarded to other logic
	localparam logic [3:0] CSR_WIN_HI = 4'h0;
	localparam logic [15:0] CSR_FWD_MASK = 16'h8780;
	localparam logic [7:0] CSR_ZERO = 8'h00;
	// values after reset
	localparam logic [7:0] CSR_RST_PTR = 8'h00;
	localparam logic [7:0] CSR_RST_ACC = 8'h00;
	// cycles the cpu idles after a program counter low write
	localparam int CSR_DUMMY_CYCLES = 1;
	typedef enum logic [0:0] {
		CSR_JMP_IDLE,
		CSR_JMP_DUMMY
	} csr_jump_state_t;
endpackage

//--- hw/csr_addr_resolve.sv
// indirect port redirection onto the pointer-selected data memory address
`timescale 1ns/10ps
module csr_addr_resolve import csr_pkg::*; #(
	parameter int ADDR_W = CSR_ADDR_W,
	parameter int SECTOR_W = CSR_SECTOR_W
) (
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [7:0] ptr0,
	input wire logic [7:0] ptra_lo,
	input wire logic [7:0] ptra_sec,
	input wire logic [7:0] ptrb_lo,
	input wire logic [7:0] ptrb_sec,
	output logic [ADDR_W-1:0] eff_addr,
	output logic redirected
);
	logic in_sector0;

	// ports exist only in sector 0; anything else passes unchanged
	always_comb begin
		in_sector0 = (req_addr[ADDR_W-1:8] == {SECTOR_W{1'b0}});
		eff_addr = req_addr;
		redirected = 1'b0;
		if (in_sector0) begin
			unique case (req_addr[7:0])
				CSR_OFF_IND0: begin
					eff_addr = {{SECTOR_W{1'b0}}, ptr0};
					redirected = 1'b1;
				end
				CSR_OFF_INDA: begin
					eff_addr = {ptra_sec[SECTOR_W-1:0], ptra_lo};
					redirected = 1'b1;
				end
				CSR_OFF_INDB: begin
					eff_addr = {ptrb_sec[SECTOR_W-1:0], ptrb_lo};
					redirected = 1'b1;
				end
				default: begin
					eff_addr = req_addr;
					redirected = 1'b0;
				end
			endcase
		end
	end
endmodule

//--- hw/csr_pc_jump.sv
// computed jump through the program counter low byte with its dummy cycle
`timescale 1ns/10ps
module csr_pc_jump import csr_pkg::*; #(
	parameter int DUMMY = CSR_DUMMY_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic pcl_wr,
	input wire logic [7:0] pcl_data,
	output logic jump_q,
	output logic [7:0] target_q,
	output logic stall_q
);
	csr_jump_state_t state_q, state_d;
	logic jump_d, stall_d;
	logic [7:0] target_d;
	logic [3:0] cnt_q, cnt_d;

	// a write while the dummy cycle runs is dropped; the cpu is stalled then
	always_comb begin
		state_d = state_q;
		jump_d = 1'b0;
		target_d = target_q;
		stall_d = stall_q;
		cnt_d = cnt_q;
		unique case (state_q)
			CSR_JMP_IDLE: begin
				stall_d = 1'b0;
				if (pcl_wr) begin
					jump_d = 1'b1;
					target_d = pcl_data;
					stall_d = 1'b1;
					cnt_d = 4'(DUMMY - 1);
					state_d = CSR_JMP_DUMMY;
				end
			end
			CSR_JMP_DUMMY: begin
				if (cnt_q == 4'h0) begin
					stall_d = 1'b0;
					state_d = CSR_JMP_IDLE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
		endcase
	end

	// registers of the jump sequencer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= CSR_JMP_IDLE;
			jump_q <= 1'b0;
			target_q <= 8'h00;
			stall_q <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			state_q <= state_d;
			jump_q <= jump_d;
			target_q <= target_d;
			stall_q <= stall_d;
			cnt_q <= cnt_d;
		end
	end
endmodule

//--- sim/csr_mem_model.sv
// behavioural data memory and peripheral space behind the forwarded port
`timescale 1ns/10ps
module csr_mem_model import csr_pkg::*; (
	input wire logic ref_clk,
	input wire logic [CSR_ADDR_W-1:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem_q [0:(1<<CSR_ADDR_W)-1];
	logic [7:0] junk_q = 8'h5A;
	// contents follow address bits 9:2, so sectors four apart read back alike
	initial begin
		for (int i = 0; i < (1 << CSR_ADDR_W); i++) begin
			mem_q[i] = i[9:2];
		end
	end
	// writes land on the strobe edge; junk toggles so a stale read cannot pass
	always @(posedge ref_clk) begin
		if (mem_wr) begin
			mem_q[mem_addr] <= mem_wdata;
		end
		junk_q <= ~junk_q;
	end
	// data only valid while the read strobe is up
	assign mem_rdata = mem_rd ? mem_q[mem_addr] : junk_q;
endmodule

//--- sim/core_special_registers_tb.sv
// self-checking bench for the core special register block
`timescale 1ns/10ps
module core_special_registers_tb import csr_pkg::*; ;
	typedef struct packed {
		logic wr;
		logic [10:0] a;
		logic [7:0] d;
		logic fwd;
		logic [10:0] ma;
		logic [7:0] rd;
	} csr_row_t;
	logic ref_clk, rst, cpu_rd, cpu_wr, alu_we, cpu_rvalid, mem_sfr, mem_rd, mem_wr, pc_jump, pc_stall;
	logic [CSR_ADDR_W-1:0] cpu_addr, mem_addr, s_addr;
	logic [7:0] cpu_wdata, alu_result, pc_low_cur, mem_rdata, cpu_rdata, mem_wdata, acc, pc_target;
	logic s_rd, s_wr, s_sfr, s_rv;
	logic [7:0] s_wd, s_rdata;
	int n_mismatch;
	int comparisons;
	csr_row_t rows [31];

	csr_top #(.ADDR_W(CSR_ADDR_W), .SECTOR_W(CSR_SECTOR_W)) csr_top_inst (
		.ref_clk(ref_clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
		.cpu_wdata(cpu_wdata), .alu_we(alu_we), .alu_result(alu_result), .pc_low_cur(pc_low_cur),
		.mem_rdata(mem_rdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .mem_addr(mem_addr),
		.mem_sfr(mem_sfr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .acc(acc),
		.pc_jump(pc_jump), .pc_target(pc_target), .pc_stall(pc_stall)
	);
	csr_mem_model csr_mem_model_inst (
		.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
	);

	// 25 MHz clock
	always #20 ref_clk = ~ref_clk;

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one request pulse; mem port sampled in the next cycle, read answer one later
	task automatic access(input logic wr, input logic [CSR_ADDR_W-1:0] a, input logic [7:0] d);
		cpu_wr = wr;
		cpu_rd = ~wr;
		cpu_addr = a;
		cpu_wdata = d;
		@(posedge ref_clk);
		#1;
		cpu_wr = 1'h0;
		cpu_rd = 1'h0;
		s_rd = mem_rd;
		s_wr = mem_wr;
		s_sfr = mem_sfr;
		s_addr = mem_addr;
		s_wd = mem_wdata;
		@(posedge ref_clk);
		#1;
		s_rv = cpu_rvalid;
		s_rdata = cpu_rdata;
	endtask

	// watchdog well past the roughly 72 cycles the tests need
	initial begin
		#(40 * 2000);
		n_mismatch++;
		$display("watchdog expired");
		end_of_test();
	end

	initial begin
		ref_clk = 1'h0;
		rst = 1'h1;
		cpu_addr = 11'h000;
		cpu_rd = 1'h0;
		cpu_wr = 1'h0;
		cpu_wdata = 8'h00;
		alu_we = 1'h0;
		alu_result = 8'h00;
		pc_low_cur = 8'hC4;
		n_mismatch = 0;
		comparisons = 0;
		// wr, address, data, forwarded, memory address, read data
		rows = '{
			'{1'h0, 11'h001, 8'h00, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h004, 8'h00, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h00E, 8'h00, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h005, 8'h00, 1'h0, 11'h000, 8'h00},
			'{1'h1, 11'h001, 8'hA3, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h001, 8'h00, 1'h0, 11'h000, 8'hA3},
			'{1'h1, 11'h003, 8'h90, 1'h0, 11'h000, 8'h00},
			'{1'h1, 11'h004, 8'h01, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h002, 8'h00, 1'h1, 11'h190, 8'h64},
			'{1'h1, 11'h00D, 8'h20, 1'h0, 11'h000, 8'h00},
			'{1'h1, 11'h00E, 8'h02, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h00C, 8'h00, 1'h1, 11'h220, 8'h88},
			'{1'h0, 11'h000, 8'h00, 1'h1, 11'h0A3, 8'h28},
			'{1'h0, 11'h1F0, 8'h00, 1'h1, 11'h1F0, 8'h7C},
			'{1'h0, 11'h150, 8'h00, 1'h1, 11'h150, 8'h54},
			'{1'h0, 11'h00B, 8'h00, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h007, 8'h00, 1'h1, 11'h007, 8'h01},
			'{1'h1, 11'h002, 8'h5A, 1'h1, 11'h190, 8'h00},
			'{1'h0, 11'h190, 8'h00, 1'h1, 11'h190, 8'h5A},
			'{1'h0, 11'h006, 8'h00, 1'h0, 11'h000, 8'hC4},
			'{1'h1, 11'h005, 8'h3C, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h005, 8'h00, 1'h0, 11'h000, 8'h3C},
			'{1'h1, 11'h001, 8'h02, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h000, 8'h00, 1'h0, 11'h000, 8'h00},
			'{1'h1, 11'h000, 8'hFF, 1'h0, 11'h000, 8'h00},
			'{1'h0, 11'h001, 8'h00, 1'h0, 11'h000, 8'h02},
			'{1'h1, 11'h001, 8'hC0, 1'h0, 11'h000, 8'h00},
			'{1'h1, 11'h000, 8'h6B, 1'h1, 11'h0C0, 8'h00},
			'{1'h1, 11'h2C0, 8'h3D, 1'h1, 11'h2C0, 8'h00},
			'{1'h0, 11'h2C0, 8'h00, 1'h1, 11'h2C0, 8'h3D},
			'{1'h0, 11'h000, 8'h00, 1'h1, 11'h0C0, 8'h6B}
		};
		repeat (3) @(posedge ref_clk);
		#1;
		rst = 1'h0;
		chk("reset outputs", 16'h0000, 16'({cpu_rvalid, mem_rd, mem_wr, pc_jump, pc_stall, acc}));
		$display("test reset done");
		foreach (rows[i]) begin
			access(rows[i].wr, rows[i].a, rows[i].d);
			chk("strobes", 16'({rows[i].fwd & ~rows[i].wr, rows[i].fwd & rows[i].wr, ~rows[i].wr}), 16'({s_rd, s_wr, s_rv}));
			if (rows[i].fwd) begin
				chk("mem_addr", 16'(rows[i].ma), 16'(s_addr));
				chk("mem_sfr", 16'(rows[i].ma[7:0] < 8'h80), 16'(s_sfr));
			end
			if (rows[i].fwd && rows[i].wr) begin
				chk("mem_wdata", 16'(rows[i].d), 16'(s_wd));
			end
			if (!rows[i].wr) begin
				chk("cpu_rdata", 16'(rows[i].rd), 16'(s_rdata));
			end
		end
		$display("test access table done");
		cpu_wr = 1'h1;
		cpu_addr = 11'h006;
		cpu_wdata = 8'h77;
		@(posedge ref_clk);
		#1;
		// a second write lands in the dummy cycle and must be dropped
		cpu_wdata = 8'h11;
		chk("jump start", 16'h0377, 16'({pc_jump, pc_stall, pc_target}));
		@(posedge ref_clk);
		#1;
		// a pointer write right before its read-back exercises the storage path
		cpu_addr = 11'h00E;
		cpu_wdata = 8'h05;
		chk("jump end", 16'h0077, 16'({pc_jump, pc_stall, pc_target}));
		$display("test jump done");
		@(posedge ref_clk);
		#1;
		cpu_wr = 1'h0;
		cpu_rd = 1'h1;
		@(posedge ref_clk);
		#1;
		cpu_addr = 11'h1F0;
		@(posedge ref_clk);
		#1;
		cpu_rd = 1'h0;
		chk("first answer", 16'h0105, 16'({cpu_rvalid, cpu_rdata}));
		chk("second fetch", 16'h09F0, 16'({mem_rd, mem_addr}));
		@(posedge ref_clk);
		#1;
		chk("second answer", 16'h017C, 16'({cpu_rvalid, cpu_rdata}));
		$display("test back to back done");
		alu_we = 1'h1;
		alu_result = 8'h5E;
		cpu_wr = 1'h1;
		cpu_addr = 11'h005;
		cpu_wdata = 8'h99;
		@(posedge ref_clk);
		#1;
		alu_we = 1'h0;
		cpu_wr = 1'h0;
		chk("acc", 16'h005E, 16'(acc));
		$display("test accumulator done");
		end_of_test();
	end
endmodule
